//--- design/dmr_regs.sv
`timescale 1ns/1ps
`include "dmr_defines.svh"
// How it works
// - Missing supervisor mode where needed is violation
// - Writes to read-only registers are violations
// - Bus violations end with bus error
// - CPU violations trap and flag register error
// - Supervisor read of trap flags clears them
// - User read of trap flags keeps them
// - Reserved read gives load bus-error trap
// - Reserved write gives store bus-error trap
// - Identification readable, writes give bus error from the bus and a trap from the CPU
// - Control supervisor-writable, resets to 0x32
module dmr_regs
   import dmr_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic req,
   input wire logic req_cpu,
   input wire logic [31:0] addr,
   input wire logic [1:0] size,
   input wire logic wr,
   input wire logic sv,
   input wire logic [31:0] wdata,
   input wire logic async_err,
   output logic ack_ff,
   output logic [31:0] rdata_ff,
   output logic bus_err_ff,
   output logic trap_ff,
   output logic trap_load_be_ff,
   output logic trap_store_be_ff,
   output logic [31:0] unit_control_ff
);
   dmr_reg_t sel;
   dmr_chk_t verdict;
   logic [31:0] sync_trap_flags_ff;
   logic [31:0] async_trap_flags_ff;
   logic [31:0] nxt_rdata;
   logic take;
   logic good;
   logic viol;
   logic res;
   logic clr_str;
   logic clr_atr;
   logic sync_set;

   dmr_check u_check (
      .addr(addr),
      .size(size),
      .wr(wr),
      .sv(sv),
      .sel(sel),
      .verdict(verdict)
   );

   assign take = req && verdict != DMR_IGN;
   assign good = take && verdict == DMR_OK;
   assign viol = take && verdict == DMR_VIOL;
   assign res = take && verdict == DMR_RES;
   assign clr_str = good && !wr && sv && sel == DMR_REG_STR;
   assign clr_atr = good && !wr && sv && sel == DMR_REG_ATR;
   assign sync_set = viol && req_cpu;

   always_comb begin
      nxt_rdata = 32'h00000000;
      unique case (sel)
         DMR_REG_ID: nxt_rdata = `DMR_ID_VAL;
         DMR_REG_CON: nxt_rdata = unit_control_ff;
         DMR_REG_STR: nxt_rdata = sync_trap_flags_ff;
         DMR_REG_ATR: nxt_rdata = async_trap_flags_ff;
         DMR_REG_RES: nxt_rdata = 32'h00000000;
         DMR_REG_NONE: nxt_rdata = 32'h00000000;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ack_ff <= 1'b0;
         rdata_ff <= 32'h00000000;
      end else begin
         ack_ff <= take;
         rdata_ff <= (good && !wr) ? nxt_rdata : 32'h00000000;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         unit_control_ff <= `DMR_CON_RST;
      end else if (good && wr && sel == DMR_REG_CON) begin
         unit_control_ff <= wdata;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         bus_err_ff <= 1'b0;
         trap_ff <= 1'b0;
         trap_load_be_ff <= 1'b0;
         trap_store_be_ff <= 1'b0;
      end else begin
         bus_err_ff <= (viol || res) && !req_cpu;
         trap_ff <= viol && req_cpu;
         trap_load_be_ff <= res && !wr;
         trap_store_be_ff <= res && wr;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sync_trap_flags_ff <= `DMR_TRAP_RST;
      end else begin
         if (clr_str) begin
            sync_trap_flags_ff <= `DMR_TRAP_RST;
         end
         if (sync_set) begin
            sync_trap_flags_ff[`DMR_REG_ERR_BIT] <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         async_trap_flags_ff <= `DMR_TRAP_RST;
      end else begin
         if (clr_atr) begin
            async_trap_flags_ff <= `DMR_TRAP_RST;
         end
         if (async_err) begin
            async_trap_flags_ff[`DMR_REG_ERR_BIT] <= 1'b1;
         end
      end
   end

   // Reset and response timing
   AST_CON_RESET: assert property (@(posedge clk_sys)
      $fell(rst) |-> unit_control_ff == 32'h00000032)
      else $error("control reset value wrong");

   AST_RST_OUTS: assert property (@(posedge clk_sys)
      rst |=> !ack_ff && !bus_err_ff && !trap_ff && !trap_load_be_ff && !trap_store_be_ff
      && rdata_ff == 32'h0 && unit_control_ff == `DMR_CON_RST
      && sync_trap_flags_ff == `DMR_TRAP_RST && async_trap_flags_ff == `DMR_TRAP_RST)
      else $error("outputs not cleared by reset");

   AST_ACK_TAKE: assert property (@(posedge clk_sys) disable iff (rst)
      take |=> ack_ff)
      else $error("register access not answered");

   AST_IGN_QUIET: assert property (@(posedge clk_sys) disable iff (rst)
      !take |=> !ack_ff && !bus_err_ff && !trap_ff && !trap_load_be_ff && !trap_store_be_ff
      && rdata_ff == 32'h0)
      else $error("response without register access");

   // Access checks
   AST_ALIGN: assert property (@(posedge clk_sys) disable iff (rst)
      take && addr[2:0] != 3'h0 |-> verdict == DMR_VIOL)
      else $error("misaligned access accepted");

   AST_SIZE: assert property (@(posedge clk_sys) disable iff (rst)
      take && size != `DMR_SIZE_WORD |-> verdict == DMR_VIOL)
      else $error("non-word access accepted");

   AST_USER_WR: assert property (@(posedge clk_sys) disable iff (rst)
      req && !sv && wr && sel == DMR_REG_CON |=> $stable(unit_control_ff) && (bus_err_ff || trap_ff))
      else $error("user write not refused");

   AST_SV_WR_OK: assert property (@(posedge clk_sys) disable iff (rst)
      take && wr && sv && sel == DMR_REG_CON && size == `DMR_SIZE_WORD |-> verdict == DMR_OK)
      else $error("supervisor control write refused");

   AST_RO_WR: assert property (@(posedge clk_sys) disable iff (rst)
      req && wr && sel == DMR_REG_ID && verdict != DMR_IGN |=> bus_err_ff || trap_ff)
      else $error("id write not refused");

   AST_FLAG_WR: assert property (@(posedge clk_sys) disable iff (rst)
      take && wr && (sel == DMR_REG_STR || sel == DMR_REG_ATR) |-> verdict == DMR_VIOL)
      else $error("trap flag write accepted");

   AST_USER_RD_OK: assert property (@(posedge clk_sys) disable iff (rst)
      take && !wr && size == `DMR_SIZE_WORD && sel != DMR_REG_RES |-> verdict == DMR_OK)
      else $error("register read refused");

   AST_RES_VERDICT: assert property (@(posedge clk_sys) disable iff (rst)
      take && size == `DMR_SIZE_WORD && addr[2:0] == 3'h0 && sel == DMR_REG_RES |-> verdict == DMR_RES)
      else $error("reserved access not flagged");

   AST_VIOL_KEEP: assert property (@(posedge clk_sys) disable iff (rst)
      viol |=> $stable(unit_control_ff))
      else $error("violation changed control");

   // Error responses
   AST_BUS_ERR: assert property (@(posedge clk_sys) disable iff (rst)
      viol && !req_cpu |=> bus_err_ff && !trap_ff)
      else $error("bus violation no error");

   AST_RES_BUS: assert property (@(posedge clk_sys) disable iff (rst)
      res && !req_cpu |=> bus_err_ff)
      else $error("reserved bus access no error");

   AST_CPU_NO_BERR: assert property (@(posedge clk_sys) disable iff (rst)
      req_cpu |=> !bus_err_ff)
      else $error("bus error on cpu access");

   AST_BUS_NO_TRAP: assert property (@(posedge clk_sys) disable iff (rst)
      !req_cpu && !clr_str |=> !trap_ff && $stable(sync_trap_flags_ff))
      else $error("cpu trap on bus access");

   AST_CPU_TRAP: assert property (@(posedge clk_sys) disable iff (rst)
      viol && req_cpu |=> trap_ff && sync_trap_flags_ff[`DMR_REG_ERR_BIT])
      else $error("cpu violation no trap");

   AST_GOOD_QUIET: assert property (@(posedge clk_sys) disable iff (rst)
      good |=> !bus_err_ff && !trap_ff && !trap_load_be_ff && !trap_store_be_ff)
      else $error("error on legal access");

   AST_RES_LOAD: assert property (@(posedge clk_sys) disable iff (rst)
      res && !wr |=> trap_load_be_ff && rdata_ff == 32'h0)
      else $error("reserved read no load trap");

   AST_RES_NO_TRAP: assert property (@(posedge clk_sys) disable iff (rst)
      res |=> !trap_ff && !$rose(sync_trap_flags_ff[`DMR_REG_ERR_BIT]))
      else $error("reserved access raised register trap");

   AST_RES_STORE: assert property (@(posedge clk_sys) disable iff (rst)
      res && wr |=> trap_store_be_ff && $stable(unit_control_ff))
      else $error("reserved write no store trap");

   AST_RES_KEEP: assert property (@(posedge clk_sys) disable iff (rst)
      res && !async_err |=> $stable(sync_trap_flags_ff) && $stable(async_trap_flags_ff))
      else $error("reserved access changed flags");

   AST_ERR_NO_DATA: assert property (@(posedge clk_sys) disable iff (rst)
      take && !good |=> rdata_ff == 32'h0)
      else $error("data returned on refused access");

   // Register contents
   AST_CON_WR: assert property (@(posedge clk_sys) disable iff (rst)
      good && wr |=> unit_control_ff == $past(wdata))
      else $error("control write lost");

   AST_CON_RD: assert property (@(posedge clk_sys) disable iff (rst)
      good && !wr && sel == DMR_REG_CON |=> rdata_ff == $past(unit_control_ff))
      else $error("control read wrong");

   AST_ID_RD: assert property (@(posedge clk_sys) disable iff (rst)
      good && !wr && sel == DMR_REG_ID |=> rdata_ff == `DMR_ID_VAL)
      else $error("id read wrong");

   AST_WR_NO_DATA: assert property (@(posedge clk_sys) disable iff (rst)
      take && wr |=> rdata_ff == 32'h0)
      else $error("data returned on write");

   AST_STR_RD: assert property (@(posedge clk_sys) disable iff (rst)
      good && !wr && sel == DMR_REG_STR |=> rdata_ff == $past(sync_trap_flags_ff))
      else $error("sync flag read wrong");

   AST_ATR_RD: assert property (@(posedge clk_sys) disable iff (rst)
      good && !wr && sel == DMR_REG_ATR |=> rdata_ff == $past(async_trap_flags_ff))
      else $error("async flag read wrong");

   // Trap flags
   AST_SV_CLR: assert property (@(posedge clk_sys) disable iff (rst)
      clr_str && !sync_set |=> sync_trap_flags_ff == 32'h0)
      else $error("supervisor read did not clear");

   AST_ATR_CLR: assert property (@(posedge clk_sys) disable iff (rst)
      clr_atr && !async_err |=> async_trap_flags_ff == 32'h0)
      else $error("supervisor read did not clear async flags");

   AST_USER_KEEP: assert property (@(posedge clk_sys) disable iff (rst)
      good && !wr && !sv && sel == DMR_REG_ATR && !async_err |=> $stable(async_trap_flags_ff) && !bus_err_ff)
      else $error("user read changed flags");

   AST_USER_STR_KEEP: assert property (@(posedge clk_sys) disable iff (rst)
      good && !wr && !sv && sel == DMR_REG_STR |=> $stable(sync_trap_flags_ff) && !trap_ff)
      else $error("user read changed sync flags");

   AST_ATR_SET: assert property (@(posedge clk_sys) disable iff (rst)
      async_err |=> async_trap_flags_ff[`DMR_REG_ERR_BIT])
      else $error("late error not recorded");

   AST_STR_ONLY_CPU: assert property (@(posedge clk_sys) disable iff (rst)
      !sync_set |=> !$rose(sync_trap_flags_ff[`DMR_REG_ERR_BIT]))
      else $error("sync flag set without cpu violation");

   AST_STR_HOLD: assert property (@(posedge clk_sys) disable iff (rst)
      !sync_set && !clr_str |=> $stable(sync_trap_flags_ff))
      else $error("sync flags changed without cause");

   AST_ATR_ONLY_LATE: assert property (@(posedge clk_sys) disable iff (rst)
      !async_err |=> !$rose(async_trap_flags_ff[`DMR_REG_ERR_BIT]))
      else $error("async flag set without late error");

   AST_FLAG_UNUSED: assert property (@(posedge clk_sys) disable iff (rst)
      ((sync_trap_flags_ff | async_trap_flags_ff) & ~(32'h1 << `DMR_REG_ERR_BIT)) == 32'h0)
      else $error("unused trap flag bit set");
endmodule

//--- design/dmr_defines.svh
`ifndef DMR_DEFINES_SVH
`define DMR_DEFINES_SVH
// Register byte addresses
`define DMR_ADDR_ID 32'hf87ffc08
`define DMR_ADDR_CON 32'hf87ffc10
`define DMR_ADDR_STR 32'hf87ffc18
`define DMR_ADDR_ATR 32'hf87ffc20
// Register space bounds
`define DMR_ADDR_BASE 32'hf87ffc00
`define DMR_ADDR_LAST 32'hf87ffcfc
`define DMR_ADDR_NBE_LO 32'hf87ffc00
// Reset values
`define DMR_CON_RST 32'h00000032
`define DMR_TRAP_RST 32'h00000000
// Identification value, arbitrary
`define DMR_ID_VAL 32'h0a5a0001
// Register-error flag position in the trap flag registers
`define DMR_REG_ERR_BIT 0
// Access size code for a word
`define DMR_SIZE_WORD 2'h2
`endif

//--- design/dmr_pkg.sv
package dmr_pkg;
   typedef enum logic [1:0] {
      DMR_OK,
      DMR_VIOL,
      DMR_RES,
      DMR_IGN
   } dmr_chk_t;
   typedef enum logic [2:0] {
      DMR_REG_ID,
      DMR_REG_CON,
      DMR_REG_STR,
      DMR_REG_ATR,
      DMR_REG_RES,
      DMR_REG_NONE
   } dmr_reg_t;
endpackage

//--- design/dmr_check.sv
`timescale 1ns/1ps
`include "dmr_defines.svh"
module dmr_check
   import dmr_pkg::*;
(
   input wire logic [31:0] addr,
   input wire logic [1:0] size,
   input wire logic wr,
   input wire logic sv,
   output dmr_reg_t sel,
   output dmr_chk_t verdict
);
   function automatic dmr_reg_t decode(input logic [31:0] a);
      dmr_reg_t r;
      r = DMR_REG_NONE;
      if (a == `DMR_ADDR_ID) begin
         r = DMR_REG_ID;
      end else if (a == `DMR_ADDR_CON) begin
         r = DMR_REG_CON;
      end else if (a == `DMR_ADDR_STR) begin
         r = DMR_REG_STR;
      end else if (a == `DMR_ADDR_ATR) begin
         r = DMR_REG_ATR;
      end else if (a >= `DMR_ADDR_BASE && a <= `DMR_ADDR_LAST) begin
         r = DMR_REG_RES;
      end
      return r;
   endfunction

   always_comb begin
      sel = decode(addr);
      verdict = DMR_OK;
      if (sel == DMR_REG_NONE) begin
         verdict = DMR_IGN;
      end else if (size != `DMR_SIZE_WORD || addr[2:0] != 3'h0) begin
         verdict = DMR_VIOL;
      end else if (sel == DMR_REG_RES) begin
         verdict = DMR_RES;
      end else if (wr && sel != DMR_REG_CON) begin
         verdict = DMR_VIOL;
      end else if (wr && !sv) begin
         verdict = DMR_VIOL;
      end
   end
endmodule

//--- tb/dmr_master.sv
`timescale 1ns/1ps
`include "dmr_defines.svh"
module dmr_master (
   input wire logic clk_sys,
   output logic req,
   output logic req_cpu,
   output logic [31:0] addr,
   output logic [1:0] size,
   output logic wr,
   output logic sv,
   output logic [31:0] wdata,
   output logic async_err
);
   initial {req, req_cpu, addr, size, wr, sv, wdata, async_err} = '0;
   task automatic acc(input logic c, input logic [31:0] a, input logic w, input logic s,
                      input logic [31:0] d, input logic [1:0] z = `DMR_SIZE_WORD);
      @(posedge clk_sys);
      #1;
      {req, req_cpu, addr, wr, sv, wdata, size} = {1'b1, c, a, w, s, d, z};
      @(posedge clk_sys);
      #1;
      // Released lines show no stale value
      {req, addr, wdata} = {1'b0, ~addr, ~wdata};
   endtask
   task automatic late_err();
      @(posedge clk_sys);
      #1;
      async_err = 1'b1;
      @(posedge clk_sys);
      #1;
      async_err = 1'b0;
   endtask
endmodule

//--- tb/data_memory_reg_access_checker_tb.sv
`timescale 1ns/1ps
`include "dmr_defines.svh"
module data_memory_reg_access_checker_tb import dmr_pkg::*;;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic req, req_cpu, wr, sv, async_err, ack, berr, trap, tld, tst;
   logic [31:0] addr, wdata, rdata, ctl;
   logic [1:0] size;
   int fail_count = 0;
   int compares = 0;
   wire [31:0] ev = {27'h0, ack, berr, trap, tld, tst};
   always #4 clk_sys = ~clk_sys;
   dmr_master M (.clk_sys(clk_sys), .req(req), .req_cpu(req_cpu), .addr(addr), .size(size),
      .wr(wr), .sv(sv), .wdata(wdata), .async_err(async_err));
   dmr_regs DUT (.clk_sys(clk_sys), .rst(rst), .req(req), .req_cpu(req_cpu), .addr(addr),
      .size(size), .wr(wr), .sv(sv), .wdata(wdata), .async_err(async_err), .ack_ff(ack),
      .rdata_ff(rdata), .bus_err_ff(berr), .trap_ff(trap), .trap_load_be_ff(tld),
      .trap_store_be_ff(tst), .unit_control_ff(ctl));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict();
      $display("compares=%0d fail_count=%0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge clk_sys);
      #1;
      rst = 1'b0;
      chk(ctl, 32'h32);
      M.acc(1'b1, `DMR_ADDR_ID, 1'b0, 1'b0, 32'h0);
      chk(rdata, `DMR_ID_VAL);
      M.acc(1'b0, `DMR_ADDR_ID, 1'b1, 1'b1, 32'h5);
      chk(ev, 32'h18);
      $display("test 1 done");
      M.acc(1'b1, `DMR_ADDR_CON, 1'b1, 1'b1, 32'h5a);
      chk(ctl, 32'h5a);
      M.acc(1'b0, `DMR_ADDR_CON, 1'b0, 1'b0, 32'h0);
      chk(rdata, 32'h5a);
      M.acc(1'b1, `DMR_ADDR_CON, 1'b1, 1'b0, 32'h77);
      chk(ev, 32'h14);
      M.acc(1'b1, `DMR_ADDR_STR, 1'b0, 1'b1, 32'h0);
      chk(rdata, 32'h1);
      M.acc(1'b1, `DMR_ADDR_STR, 1'b0, 1'b1, 32'h0);
      chk(rdata, 32'h0);
      $display("test 2 done");
      M.acc(1'b0, `DMR_ADDR_CON, 1'b1, 1'b1, 32'h0, 2'h1);
      chk(ev, 32'h18);
      chk(ctl, 32'h5a);
      M.acc(1'b1, 32'hf87ffc28, 1'b0, 1'b1, 32'h0);
      chk(ev, 32'h12);
      M.acc(1'b1, 32'hf87ffc30, 1'b1, 1'b1, 32'hff);
      chk(ev, 32'h11);
      chk(ctl, 32'h5a);
      $display("test 3 done");
      M.acc(1'b1, `DMR_ADDR_ID, 1'b1, 1'b1, 32'h0);
      chk(ev, 32'h14);
      rst = 1'b1;
      repeat (2) @(posedge clk_sys);
      #1;
      rst = 1'b0;
      chk(ctl, 32'h32);
      M.acc(1'b1, `DMR_ADDR_STR, 1'b0, 1'b1, 32'h0);
      chk(rdata, 32'h0);
      M.late_err();
      M.acc(1'b1, `DMR_ADDR_ATR, 1'b0, 1'b0, 32'h0);
      chk(ev, 32'h10);
      M.acc(1'b1, `DMR_ADDR_ATR, 1'b0, 1'b1, 32'h0);
      chk(rdata, 32'h1);
      M.acc(1'b1, `DMR_ADDR_ATR, 1'b0, 1'b1, 32'h0);
      chk(rdata, 32'h0);
      fork
         M.late_err();
         M.acc(1'b1, `DMR_ADDR_ATR, 1'b0, 1'b1, 32'h0);
      join
      chk(rdata, 32'h0);
      M.acc(1'b1, `DMR_ADDR_ATR, 1'b0, 1'b1, 32'h0);
      chk(rdata, 32'h1);
      $display("test 4 done");
      print_verdict();
   end
endmodule
